// ==== dv/parallel_host_port_mailbox_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// Testbench top.
// ****************
module parallel_host_port_mailbox_tb;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic bus16 = 1'b1, comb = 1'b0, swap = 1'b0, pol = 1'b0;
  logic cs_n, cd, wr_n, rd_n, dev_oe, wt, wt_oe, host_irq_o, cpu_irq_o, cpu_rd_req_o;
  logic [15:0] host_d, dev_d, bus_w, cpu_flag_o, wd, cpu_rd_data_i = 16'h0000;
  logic [15:0] host_irq_mask_i = 16'h0000, cpu_flag_clr_i = 16'h0000, cpu_evt_clr_i = 16'h0000;
  logic cpu_wr_valid_o, cpu_wr_direct_o, rd_direct, cpu_rd_valid_i = 1'b0, ready = 1'b1;
  logic [7:0] wr_pg, wr_ofs, rd_pg, rd_ofs;
  logic [1:0] rd_wait = 2'h0;
  logic [32:0] wr_q[$];
  int err_total = 0;
  int cmp_count = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  // The wire level seen by both ends of the data bus.
  assign bus_w = dev_oe ? dev_d : host_d;
  phpm_port phpm_port_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cfg_bus16_i(bus16),
    .cfg_combined_strobe_i(comb), .cfg_byte_swap_i(swap), .cfg_wait_en_i(1'b1),
    .cfg_wait_pol_i(pol), .port_chip_select_n_i(cs_n), .command_data_select_i(cd),
    .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .parallel_data_bus_i(bus_w),
    .parallel_data_bus_o(dev_d), .parallel_data_bus_oe_o(dev_oe), .wait_strobe_o(wt),
    .wait_strobe_oe_o(wt_oe), .host_irq_mask_i(host_irq_mask_i), .cpu_irq_mask_i(16'h0000),
    .cpu_flag_clr_i(cpu_flag_clr_i), .cpu_evt_clr_i(cpu_evt_clr_i), .host_irq_o(host_irq_o),
    .cpu_irq_o(cpu_irq_o), .cpu_flag_o(cpu_flag_o), .cpu_wr_valid_o(cpu_wr_valid_o),
    .cpu_wr_ready_i(ready), .cpu_wr_direct_o(cpu_wr_direct_o), .cpu_wr_page_o(wr_pg),
    .cpu_wr_ofs_o(wr_ofs), .cpu_wr_data_o(wd), .cpu_rd_req_o(cpu_rd_req_o),
    .cpu_rd_direct_o(rd_direct), .cpu_rd_page_o(rd_pg), .cpu_rd_ofs_o(rd_ofs),
    .cpu_rd_valid_i(cpu_rd_valid_i), .cpu_rd_data_i(cpu_rd_data_i));
  phpm_host_model phpm_host_model_inst (.ref_clk_i(ref_clk_i), .cfg_bus16_i(bus16),
    .cfg_combined_strobe_i(comb), .cfg_wait_pol_i(pol), .wait_strobe_i(wt),
    .wait_strobe_oe_i(wt_oe), .bus_i(bus_w), .port_chip_select_n_o(cs_n),
    .command_data_select_o(cd), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
    .data_o(host_d));
  // Processor side: answers reads after a few cycles, logs taken writes.
  always @(negedge ref_clk_i) begin
    cpu_rd_valid_i <= cpu_rd_req_o && !cpu_rd_valid_i && rd_wait == 2'h3;
    rd_wait <= (cpu_rd_req_o && !cpu_rd_valid_i) ? rd_wait + 2'h1 : 2'h0;
    if (cpu_rd_req_o && !cpu_rd_valid_i && rd_wait == 2'h3) begin
      cpu_rd_data_i <= (rd_direct && rd_ofs == 8'h00) ? cpu_flag_o :
        {rd_direct ? 8'h00 : rd_pg, rd_ofs} ^ 16'ha5a5;
    end
  end
  always @(posedge ref_clk_i) begin
    if (rstn_i && cpu_wr_valid_o && ready) begin
      wr_q.push_back({cpu_wr_direct_o, wr_pg, wr_ofs, wd});
    end
  end
  function automatic logic [32:0] lastw();
    return (wr_q.size() > 0) ? wr_q[$] : 33'h1ffffffff;
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic c, input logic [15:0] d);
    logic [15:0] x;
    phpm_host_model_inst.xfer(1'b0, c, d, x);
  endtask
  task automatic r(input logic c, output logic [15:0] d);
    phpm_host_model_inst.xfer(1'b1, c, 16'h0000, d);
  endtask
  task automatic pulse(input logic [15:0] f, input logic [15:0] e);
    cpu_flag_clr_i = f;
    cpu_evt_clr_i = e;
    @(negedge ref_clk_i);
    cpu_flag_clr_i = 16'h0000;
    cpu_evt_clr_i = 16'h0000;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task automatic t_reset();
    logic [15:0] s;
    r(1'b1, s);
    chk(s, 16'h0000);
    chk({wt_oe, wt, cpu_flag_o}, {2'b11, 16'h0000});
    $display("test reset done");
  endtask
  task automatic t_flags();
    logic [15:0] s;
    w(1'b1, 16'h2000);
    w(1'b0, 16'h0005);
    repeat (4) @(negedge ref_clk_i);
    chk({cpu_irq_o, cpu_flag_o}, {1'b1, 16'h0005});
    w(1'b1, 16'h2000);
    w(1'b0, 16'h0000);
    pulse(16'h0000, 16'hffff);
    chk({cpu_irq_o, cpu_flag_o}, {1'b0, 16'h0005});
    host_irq_mask_i = 16'h0004;
    pulse(16'h0001, 16'h0000);
    chk({host_irq_o, cpu_flag_o}, {1'b1, 16'h0004});
    w(1'b1, 16'h3000);
    r(1'b0, s);
    chk(s, 16'h0004);
    pulse(16'h0004, 16'h0000);
    chk({host_irq_o, cpu_flag_o}, 17'h00000);
    $display("test flags done");
  endtask
  task automatic t_paged();
    logic [15:0] s;
    w(1'b1, 16'h1003);
    r(1'b1, s);
    chk(s, 16'h0300);
    w(1'b1, 16'h4100);
    w(1'b0, 16'h0002);
    r(1'b1, s);
    chk(s[2], 1'b1);
    w(1'b0, 16'habcd);
    repeat (4) @(negedge ref_clk_i);
    chk(lastw() & 33'h1ff00ffff, {1'b0, 8'h03, 8'h00, 16'habcd});
    w(1'b0, 16'h4009);
    w(1'b0, 16'h1111);
    repeat (4) @(negedge ref_clk_i);
    chk(lastw(), {1'b0, 8'h03, 8'h09, 16'h1111});
    w(1'b1, 16'h4100);
    w(1'b0, 16'h2222);
    w(1'b1, 16'h4007);
    w(1'b0, 16'h3333);
    repeat (4) @(negedge ref_clk_i);
    chk(lastw(), {1'b0, 8'h03, 8'h07, 16'h3333});
    w(1'b1, 16'h5002);
    r(1'b0, s);
    chk(s, 16'ha6a7);
    $display("test paged done");
  endtask
  task automatic t_modes();
    logic [15:0] s;
    logic [7:0] m;
    for (m = 8'h00; m < 8'h03; m++) begin
      swap = (m == 8'h00);
      bus16 = (m != 8'h01);
      comb = (m == 8'h02);
      w(1'b1, 16'h4004 + {8'h00, m});
      w(1'b0, 16'h3412);
      r(1'b1, s);
      chk(lastw(), {1'b0, 8'h03, 8'h04 + m, m == 8'h00 ? 16'h1234 : 16'h3412});
      chk(s, bus16 ? 16'h0300 : 16'h0000);
    end
    swap = 1'b0;
    bus16 = 1'b1;
    comb = 1'b0;
    $display("test modes done");
  endtask
  task automatic t_cs_wait();
    int n;
    int k;
    n = wr_q.size();
    phpm_host_model_inst.cs_off = 1'b1;
    w(1'b1, 16'h4001);
    w(1'b0, 16'h9999);
    phpm_host_model_inst.cs_off = 1'b0;
    chk(33'(wr_q.size()), 33'(n));
    pol = 1'b1;
    ready = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(wt, 1'b0);
    w(1'b1, 16'h4f00);
    for (k = 0; k < 4; k++) w(1'b0, 16'hc000 + k[15:0]);
    repeat (4) @(negedge ref_clk_i);
    chk(wt, 1'b1);
    ready = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    chk({wt, lastw() & 33'h1ff00ffff}, {1'b0, 1'b0, 8'h03, 8'h00, 16'hc003});
    pol = 1'b0;
    $display("test select and wait done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence: reset held 12 cycles, then each test in turn.
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    t_reset();
    t_flags();
    t_paged();
    t_modes();
    t_cs_wait();
    complete_run();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #40000;
    err_total++;
    complete_run();
  end
endmodule
bind phpm_port phpm_port_monitor phpm_port_monitor_inst (.ref_clk_i, .rstn_i,
  .cfg_wait_en_i, .cfg_wait_pol_i, .port_chip_select_n_i, .parallel_data_bus_oe_o,
  .wait_strobe_o, .wait_strobe_oe_o, .host_irq_mask_i, .cpu_irq_mask_i, .cpu_flag_clr_i,
  .host_irq_o, .cpu_irq_o, .cpu_flag_o, .cpu_wr_valid_o, .cpu_wr_ready_i, .cpu_wr_data_o,
  .cpu_rd_req_o);
`default_nettype wire

// ==== dv/phpm_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// Host processor on the asynchronous parallel bus.
// ****************
module phpm_host_model (
  input wire logic ref_clk_i,
  input wire logic cfg_bus16_i,
  input wire logic cfg_combined_strobe_i,
  input wire logic cfg_wait_pol_i,
  input wire logic wait_strobe_i,
  input wire logic wait_strobe_oe_i,
  input wire logic [15:0] bus_i,
  output var logic port_chip_select_n_o,
  output var logic command_data_select_o,
  output var logic write_strobe_n_o,
  output var logic read_strobe_n_o,
  output var logic [15:0] data_o
);
  logic cs_off = 1'b0;
  // Wait pin with the board pull toward the inactive level.
  function automatic logic busy();
    return wait_strobe_oe_i && (wait_strobe_i == cfg_wait_pol_i);
  endfunction
  // One word, split high byte first on the narrow bus; waits out busy.
  task automatic xfer(input logic rd, input logic cd, input logic [15:0] wd,
                      output logic [15:0] rdat);
    int k;
    int t;
    rdat = 16'h0000;
    for (k = 0; k < (cfg_bus16_i ? 1 : 2); k++) begin
      t = 0;
      while (!rd && busy() && t < 400) begin
        @(negedge ref_clk_i);
        t++;
      end
      port_chip_select_n_o = cs_off;
      command_data_select_o = cd;
      data_o = rd ? ~data_o : (cfg_bus16_i ? wd : {8'h00, k == 0 ? wd[15:8] : wd[7:0]});
      write_strobe_n_o = cfg_combined_strobe_i ? 1'b0 : rd;
      read_strobe_n_o = cfg_combined_strobe_i ? rd : ~rd;
      repeat (4) @(negedge ref_clk_i);
      t = 0;
      while (rd && busy() && t < 400) begin
        @(negedge ref_clk_i);
        t++;
      end
      if (rd) begin
        repeat (2) @(negedge ref_clk_i);
        rdat = cfg_bus16_i ? bus_i : {rdat[7:0], bus_i[7:0]};
      end
      port_chip_select_n_o = 1'b1;
      write_strobe_n_o = 1'b1;
      read_strobe_n_o = 1'b1;
      data_o = ~data_o;
      repeat (4) @(negedge ref_clk_i);
    end
  endtask
  initial begin
    port_chip_select_n_o = 1'b1;
    command_data_select_o = 1'b0;
    write_strobe_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    data_o = 16'h5a5a;
  end
endmodule
`default_nettype wire

// ==== dv/phpm_port_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// Checker on the host port pins and processor side.
// ****************
module phpm_port_monitor (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cfg_wait_en_i,
  input wire logic cfg_wait_pol_i,
  input wire logic port_chip_select_n_i,
  input wire logic parallel_data_bus_oe_o,
  input wire logic wait_strobe_o,
  input wire logic wait_strobe_oe_o,
  input wire logic [15:0] host_irq_mask_i,
  input wire logic [15:0] cpu_irq_mask_i,
  input wire logic [15:0] cpu_flag_clr_i,
  input wire logic host_irq_o,
  input wire logic cpu_irq_o,
  input wire logic [15:0] cpu_flag_o,
  input wire logic cpu_wr_valid_o,
  input wire logic cpu_wr_ready_i,
  input wire logic [15:0] cpu_wr_data_o,
  input wire logic cpu_rd_req_o
);
  logic [3:0] cs_idle_cnt;
  // Counts cycles with chip select off, so host writes are known to be over.
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_idle_cnt <= 4'h0;
    end else if (!port_chip_select_n_i) begin
      cs_idle_cnt <= 4'h0;
    end else if (cs_idle_cnt != 4'hf) begin
      cs_idle_cnt <= cs_idle_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wait_oe;
    1'b1 |=> (wait_strobe_oe_o == $past(cfg_wait_en_i));
  endproperty
  a_wait_oe: assert property (p_wait_oe) else $error("wait enable mismatch");
  property p_cs_ignore;
    port_chip_select_n_i [*6] |-> !parallel_data_bus_oe_o;
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("bus driven without select");
  property p_no_set;
    (cs_idle_cnt > 4'h8) |-> ((cpu_flag_o & ~$past(cpu_flag_o)) == 16'h0000);
  endproperty
  a_no_set: assert property (p_no_set) else $error("flag set without host");
  property p_clear;
    (cs_idle_cnt > 4'h3) && (|cpu_flag_clr_i) |=> ((cpu_flag_o & $past(cpu_flag_clr_i)) == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_cpu_irq;
    ((cpu_flag_o & ~$past(cpu_flag_o) & ~cpu_irq_mask_i) != 16'h0000) |-> ##[0:2] cpu_irq_o;
  endproperty
  a_cpu_irq: assert property (p_cpu_irq) else $error("no processor interrupt");
  property p_host_irq;
    ((~cpu_flag_o & $past(cpu_flag_o) & ~host_irq_mask_i) != 16'h0000) |-> ##[0:2] host_irq_o;
  endproperty
  a_host_irq: assert property (p_host_irq) else $error("no host interrupt");
  property p_wait_fetch;
    cpu_rd_req_o && $past(cpu_rd_req_o) |-> (wait_strobe_o == cfg_wait_pol_i);
  endproperty
  a_wait_fetch: assert property (p_wait_fetch) else $error("wait idle during fetch");
  property p_fifo_hold;
    cpu_wr_valid_o && !cpu_wr_ready_i |=> cpu_wr_valid_o && $stable(cpu_wr_data_o);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("write entry dropped");
  c_cpu_irq: cover property (cpu_irq_o);
  c_host_irq: cover property (host_irq_o);
  c_stall: cover property (cpu_wr_valid_o && !cpu_wr_ready_i);
endmodule
`default_nettype wire

// ==== logic/phpm_defs.vh ====
`ifndef PHPM_DEFS_VH
`define PHPM_DEFS_VH

// ********************************************************************
// Command word layout, always taken big-endian.
// ********************************************************************
`define PHPM_OP_MSB 15
`define PHPM_OP_LSB 12
`define PHPM_CNT_MSB 11
`define PHPM_CNT_LSB 8
`define PHPM_OFS_MSB 7
`define PHPM_OFS_LSB 0

// ********************************************************************
// Command opcodes.
// ********************************************************************
`define PHPM_OP_SELPAGE 4'h1
`define PHPM_OP_DIR_WR 4'h2
`define PHPM_OP_DIR_RD 4'h3
`define PHPM_OP_PG_WR 4'h4
`define PHPM_OP_PG_RD 4'h5

// ********************************************************************
// Direct page offset of the mailbox flag register.
// ********************************************************************
`define PHPM_FLAG_OFS 8'h00

// ********************************************************************
// Status word bit positions and page field.
// ********************************************************************
`define PHPM_ST_WAIT 0
`define PHPM_ST_INT 1
`define PHPM_ST_CMD 2
`define PHPM_ST_PAGE_MSB 15
`define PHPM_ST_PAGE_LSB 8

// ********************************************************************
// Write FIFO geometry: direct bit, page, offset, data.
// ********************************************************************
`define PHPM_FIFO_W 33
`define PHPM_FIFO_D 4
`define PHPM_FIFO_AW 2

// ********************************************************************
// Reset values and small constants.
// ********************************************************************
`define PHPM_Z16 16'h0000
`define PHPM_Z8 8'h00
`define PHPM_Z5 5'h00
`define PHPM_Z4 4'h0
`define PHPM_ONE5 5'h01
`define PHPM_ONE8 8'h01

`endif

// ==== logic/phpm_port.v ====
// Contract
// R1 - All mailbox flags in one 16-bit register
// R2 - Host writes set flags, processor clears
// R3 - Flag falling raises maskable host interrupt
// R4 - Flag rising raises maskable processor interrupt
// R5 - Mailboxes carry data one direction only
// R6 - Host waits for flag zero first
// R7 - Host selects page before paged writes
// R8 - First mailbox word holds message length
// R9 - Host writes one to hand ownership
// R10 - Transaction is command word then data
// R11 - Separate strobes or direction plus data strobe
// R12 - Direction strobe high reads, low writes
// R13 - 8-bit or 16-bit bus width
// R14 - Strobes ignored while chip select high
// R15 - Wait output active while interface busy
// R16 - Wait polarity programmable, tri-state by default
// R17 - Byte swap on data, commands big-endian
// R18 - Select-high read returns status word
// R19 - Status: wait, interrupt, command busy, page
// R20 - Select-high write restarts command parser
// R21 - Status read leaves parser unchanged
// R22 - After completed command next word commands
// R23 - Strobes synchronised; data taken at strobe end
`timescale 1ns/100ps
`default_nettype none
`include "phpm_defs.vh"

// ********************************************************************
// Small FIFO with valid and ready on both sides.
// ********************************************************************
module phpm_fifo #(
  parameter W = 33,
  parameter D = 4,
  parameter AW = 2
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  localparam [AW:0] DEPTH = D;
  localparam [AW:0] ZERO = 0;
  localparam [AW:0] ONE = 1;
  localparam [AW-1:0] PONE = 1;
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  reg [AW:0] cnt_next;
  reg valid_reg;
  wire push;
  wire pop;

  // Full and empty follow the fill count.
  assign in_ready_o = (cnt_reg != DEPTH);
  assign out_valid_o = valid_reg;
  assign out_data_o = mem[rp_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = valid_reg & out_ready_i;

  // Next fill count.
  always @* begin
    cnt_next = cnt_reg;
    if (push & ~pop) begin
      cnt_next = cnt_reg + ONE;
    end else if (pop & ~push) begin
      cnt_next = cnt_reg - ONE;
    end
  end

  // Pointers, count and registered valid.
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= ZERO;
      valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      valid_reg <= (cnt_next != ZERO);
      if (push) begin
        wp_reg <= wp_reg + PONE;
      end
      if (pop) begin
        rp_reg <= rp_reg + PONE;
      end
    end
  end

  // Storage has no reset.
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end
endmodule

// ********************************************************************
// Parallel host port with mailbox flags.
// ********************************************************************
module phpm_port (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire cfg_bus16_i,
  input wire cfg_combined_strobe_i,
  input wire cfg_byte_swap_i,
  input wire cfg_wait_en_i,
  input wire cfg_wait_pol_i,
  input wire port_chip_select_n_i,
  input wire command_data_select_i,
  input wire write_strobe_n_i,
  input wire read_strobe_n_i,
  input wire [15:0] parallel_data_bus_i,
  output reg [15:0] parallel_data_bus_o,
  output reg parallel_data_bus_oe_o,
  output reg wait_strobe_o,
  output reg wait_strobe_oe_o,
  input wire [15:0] host_irq_mask_i,
  input wire [15:0] cpu_irq_mask_i,
  input wire [15:0] cpu_flag_clr_i,
  input wire [15:0] cpu_evt_clr_i,
  output reg host_irq_o,
  output reg cpu_irq_o,
  output reg [15:0] cpu_flag_o,
  output wire cpu_wr_valid_o,
  input wire cpu_wr_ready_i,
  output wire cpu_wr_direct_o,
  output wire [7:0] cpu_wr_page_o,
  output wire [7:0] cpu_wr_ofs_o,
  output wire [15:0] cpu_wr_data_o,
  output reg cpu_rd_req_o,
  output reg cpu_rd_direct_o,
  output reg [7:0] cpu_rd_page_o,
  output reg [7:0] cpu_rd_ofs_o,
  input wire cpu_rd_valid_i,
  input wire [15:0] cpu_rd_data_i
);
  localparam [1:0] RS_IDLE = 2'b00;
  localparam [1:0] RS_FETCH = 2'b01;
  localparam [1:0] RS_READY = 2'b10;

  reg wr_s1_reg, wr_s2_reg, wr_s3_reg;
  reg rd_s1_reg, rd_s2_reg, rd_s3_reg;
  reg a1_reg, a2_reg, a3_reg;
  reg [15:0] d1_reg, d2_reg, d3_reg;
  reg ph_reg, ph_next, mark_reg, mark_next, rph_reg, rph_next;
  reg [7:0] hi_reg, hi_next;
  reg command_in_progress_reg, command_in_progress_next;
  reg [3:0] op_reg, op_next;
  reg [4:0] rem_reg, rem_next;
  reg [7:0] ofs_reg, ofs_next, page_reg, page_next;
  reg [1:0] rs_reg, rs_next;
  reg [15:0] rbuf_reg, rbuf_next;
  reg rstat_reg, rstat_next, req_next;
  reg [15:0] flag_reg, flag_next, set_bits;
  reg [15:0] hevt_reg, hevt_next, cevt_reg, cevt_next;
  reg hevt_clr, busy_reg, push_v, word_ok, word_cmd, is_cmd, direct;
  reg [15:0] word, dw, st, rbw, dout;
  wire wr_raw, rd_raw, wr_end, rd_start, rd_end, fifo_ready;

  // ******************************************************************
  // Strobe decode and synchronisers.
  // ******************************************************************

  // Decode strobes per style, gated by chip select. [R11] [R12] [R14]
  assign wr_raw = ~port_chip_select_n_i & (cfg_combined_strobe_i ?
                  (~write_strobe_n_i & ~read_strobe_n_i) : ~write_strobe_n_i);
  assign rd_raw = ~port_chip_select_n_i & (cfg_combined_strobe_i ?
                  (~write_strobe_n_i & read_strobe_n_i) : ~read_strobe_n_i);

  // Strobes pass three flops; select and data ride an equal pipeline. [R23]
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_s1_reg <= 1'b0;
      wr_s2_reg <= 1'b0;
      wr_s3_reg <= 1'b0;
      rd_s1_reg <= 1'b0;
      rd_s2_reg <= 1'b0;
      rd_s3_reg <= 1'b0;
      a1_reg <= 1'b0;
      a2_reg <= 1'b0;
      a3_reg <= 1'b0;
      d1_reg <= `PHPM_Z16;
      d2_reg <= `PHPM_Z16;
      d3_reg <= `PHPM_Z16;
    end else begin
      wr_s1_reg <= wr_raw;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
      rd_s1_reg <= rd_raw;
      rd_s2_reg <= rd_s1_reg;
      rd_s3_reg <= rd_s2_reg;
      a1_reg <= command_data_select_i;
      a2_reg <= a1_reg;
      a3_reg <= a2_reg;
      d1_reg <= parallel_data_bus_i;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end

  // A write is taken when its strobe ends, with the last low sample. [R23]
  assign wr_end = wr_s3_reg & ~wr_s2_reg;
  assign rd_start = rd_s2_reg & ~rd_s3_reg;
  assign rd_end = rd_s3_reg & ~rd_s2_reg;

  // ******************************************************************
  // Write FIFO toward the internal processor.
  // ******************************************************************

  // Host writes queue here; a full FIFO shows as busy on the wait pin.
  phpm_fifo #(
    .W(`PHPM_FIFO_W),
    .D(`PHPM_FIFO_D),
    .AW(`PHPM_FIFO_AW)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_v),
    .in_ready_o(fifo_ready),
    .in_data_i({direct, page_reg, ofs_reg, dw}),
    .out_valid_o(cpu_wr_valid_o),
    .out_ready_i(cpu_wr_ready_i),
    .out_data_o({cpu_wr_direct_o, cpu_wr_page_o, cpu_wr_ofs_o, cpu_wr_data_o})
  );

  // ******************************************************************
  // Word assembly, parser, read fetch and mailbox flags.
  // ******************************************************************

  // Next state of the whole host-side engine.
  always @* begin
    ph_next = ph_reg;
    mark_next = mark_reg;
    hi_next = hi_reg;
    rph_next = rph_reg;
    command_in_progress_next = command_in_progress_reg;
    op_next = op_reg;
    rem_next = rem_reg;
    ofs_next = ofs_reg;
    page_next = page_reg;
    rs_next = rs_reg;
    rbuf_next = rbuf_reg;
    rstat_next = rstat_reg;
    req_next = cpu_rd_req_o;
    set_bits = `PHPM_Z16;
    hevt_clr = 1'b0;
    push_v = 1'b0;
    word_ok = 1'b0;
    word = d3_reg;
    word_cmd = a3_reg;
    direct = (op_reg == `PHPM_OP_DIR_WR) | (op_reg == `PHPM_OP_DIR_RD);
    // Narrow mode pairs bytes, high byte first. [R13]
    if (wr_end) begin
      if (cfg_bus16_i) begin
        word_ok = 1'b1;
      end else if (~ph_reg | (a3_reg & ~mark_reg)) begin
        hi_next = d3_reg[7:0];
        ph_next = 1'b1;
        mark_next = a3_reg;
      end else begin
        word = {hi_reg, d3_reg[7:0]};
        word_ok = 1'b1;
        word_cmd = mark_reg | a3_reg;
        ph_next = 1'b0;
        mark_next = 1'b0;
      end
    end
    // Data words swap when asked; commands never do. [R17]
    dw = cfg_byte_swap_i ? {word[7:0], word[15:8]} : word;
    // Select-high write, or idle parser, makes a command. [R20] [R22] [R10]
    is_cmd = word_cmd | ~command_in_progress_reg;
    if (word_ok & is_cmd) begin
      op_next = word[`PHPM_OP_MSB:`PHPM_OP_LSB];
      ofs_next = word[`PHPM_OFS_MSB:`PHPM_OFS_LSB];
      rem_next = {1'b0, word[`PHPM_CNT_MSB:`PHPM_CNT_LSB]} + `PHPM_ONE5;
      rs_next = RS_IDLE;
      req_next = 1'b0;
      rph_next = 1'b0;
      case (word[`PHPM_OP_MSB:`PHPM_OP_LSB])
        `PHPM_OP_SELPAGE: begin
          page_next = word[`PHPM_OFS_MSB:`PHPM_OFS_LSB];
          command_in_progress_next = 1'b0;
        end
        `PHPM_OP_DIR_WR, `PHPM_OP_PG_WR: begin
          command_in_progress_next = 1'b1;
        end
        `PHPM_OP_DIR_RD, `PHPM_OP_PG_RD: begin
          command_in_progress_next = 1'b1;
          rs_next = RS_FETCH;
        end
        default: begin
          command_in_progress_next = 1'b0;
        end
      endcase
    end else if (word_ok & (rs_reg == RS_IDLE)) begin
      // Data words of a write command; reads ignore written data. [R5] [R8]
      if (direct & (ofs_reg == `PHPM_FLAG_OFS)) begin
        set_bits = dw;
      end else begin
        push_v = 1'b1;
      end
      ofs_next = ofs_reg + `PHPM_ONE8;
      rem_next = rem_reg - `PHPM_ONE5;
      command_in_progress_next = (rem_reg != `PHPM_ONE5);
    end
    // Fetch the next read word ahead of the host strobe.
    if (rs_reg == RS_FETCH) begin
      if (direct & (ofs_reg == `PHPM_FLAG_OFS)) begin
        rbuf_next = flag_reg;
        hevt_clr = 1'b1;
        rs_next = RS_READY;
      end else if (cpu_rd_req_o & cpu_rd_valid_i) begin
        rbuf_next = cpu_rd_data_i;
        req_next = 1'b0;
        rs_next = RS_READY;
      end else begin
        req_next = 1'b1;
      end
    end
    // Status reads touch no parser state. [R18] [R21]
    if (rd_start) begin
      rstat_next = a2_reg;
    end
    if (rd_end & ~rstat_reg & (rs_reg == RS_READY)) begin
      if (~cfg_bus16_i & ~rph_reg) begin
        rph_next = 1'b1;
      end else begin
        rph_next = 1'b0;
        ofs_next = ofs_reg + `PHPM_ONE8;
        rem_next = rem_reg - `PHPM_ONE5;
        command_in_progress_next = (rem_reg != `PHPM_ONE5);
        rs_next = (rem_reg != `PHPM_ONE5) ? RS_FETCH : RS_IDLE;
      end
    end
    // Host only sets, processor only clears; a set wins. [R1] [R2] [R9]
    flag_next = (flag_reg & ~cpu_flag_clr_i) | set_bits;
    // Falls flag the host, rises flag the processor. [R3] [R4]
    hevt_next = (hevt_reg & ~{16{hevt_clr}}) | (flag_reg & ~flag_next);
    cevt_next = (cevt_reg & ~cpu_evt_clr_i) | (flag_next & ~flag_reg);
  end

  // Status word and read data selection. [R19]
  always @* begin
    st = `PHPM_Z16;
    st[`PHPM_ST_WAIT] = busy_reg;
    st[`PHPM_ST_INT] = host_irq_o;
    st[`PHPM_ST_CMD] = command_in_progress_reg;
    st[`PHPM_ST_PAGE_MSB:`PHPM_ST_PAGE_LSB] = page_reg;
    rbw = cfg_byte_swap_i ? {rbuf_reg[7:0], rbuf_reg[15:8]} : rbuf_reg;
    if (a2_reg) begin
      dout = st;
    end else if (cfg_bus16_i) begin
      dout = rbw;
    end else begin
      dout = {`PHPM_Z8, rph_reg ? rbw[7:0] : rbw[15:8]};
    end
  end

  // State registers and registered outputs.
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_reg <= 1'b0;
      mark_reg <= 1'b0;
      hi_reg <= `PHPM_Z8;
      rph_reg <= 1'b0;
      command_in_progress_reg <= 1'b0;
      op_reg <= `PHPM_Z4;
      rem_reg <= `PHPM_Z5;
      ofs_reg <= `PHPM_Z8;
      page_reg <= `PHPM_Z8;
      rs_reg <= RS_IDLE;
      rbuf_reg <= `PHPM_Z16;
      rstat_reg <= 1'b0;
      flag_reg <= `PHPM_Z16;
      hevt_reg <= `PHPM_Z16;
      cevt_reg <= `PHPM_Z16;
      busy_reg <= 1'b0;
      host_irq_o <= 1'b0;
      cpu_irq_o <= 1'b0;
      cpu_flag_o <= `PHPM_Z16;
      cpu_rd_req_o <= 1'b0;
      cpu_rd_direct_o <= 1'b0;
      cpu_rd_page_o <= `PHPM_Z8;
      cpu_rd_ofs_o <= `PHPM_Z8;
      parallel_data_bus_o <= `PHPM_Z16;
      parallel_data_bus_oe_o <= 1'b0;
      wait_strobe_o <= 1'b0;
      wait_strobe_oe_o <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      mark_reg <= mark_next;
      hi_reg <= hi_next;
      rph_reg <= rph_next;
      command_in_progress_reg <= command_in_progress_next;
      op_reg <= op_next;
      rem_reg <= rem_next;
      ofs_reg <= ofs_next;
      page_reg <= page_next;
      rs_reg <= rs_next;
      rbuf_reg <= rbuf_next;
      rstat_reg <= rstat_next;
      flag_reg <= flag_next;
      hevt_reg <= hevt_next;
      cevt_reg <= cevt_next;
      host_irq_o <= |(hevt_next & ~host_irq_mask_i); // [R3]
      cpu_irq_o <= |(cevt_next & ~cpu_irq_mask_i); // [R4]
      cpu_flag_o <= flag_next;
      cpu_rd_req_o <= req_next;
      cpu_rd_direct_o <= direct;
      cpu_rd_page_o <= page_reg;
      cpu_rd_ofs_o <= ofs_next;
      // Busy while a read word is pending or the FIFO is full. [R15]
      busy_reg <= (rs_next == RS_FETCH) | ~fifo_ready;
      // Wait pin polarity and drive are programmable, off by default. [R16]
      wait_strobe_o <= cfg_wait_pol_i ?
                       ((rs_next == RS_FETCH) | ~fifo_ready) :
                       ~((rs_next == RS_FETCH) | ~fifo_ready);
      wait_strobe_oe_o <= cfg_wait_en_i;
      // Drive the bus while a synchronised read strobe is active. [R18]
      parallel_data_bus_o <= dout;
      parallel_data_bus_oe_o <= rd_s2_reg;
    end
  end
endmodule
`default_nettype wire
